// ### design/sdc_pkg.sv
// Package: register map, fields, timing constants and carrier types for the card host block
package sdc_pkg;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] SDC_SYSCTL_OFF   = 8'h00;
	localparam logic [7:0] SDC_PRESENT_OFF  = 8'h04;
	localparam logic [7:0] SDC_DIVIDER_OFF  = 8'h08;
	localparam logic [7:0] SDC_ADMA_OFF     = 8'h0C;
	localparam logic [7:0] SDC_IRQ_STAT_OFF = 8'h10;
	localparam logic [7:0] SDC_IRQ_CLR_OFF  = 8'h14;
	localparam logic [7:0] SDC_IRQ_EN_OFF   = 8'h18;
	localparam logic [7:0] SDC_DESC_OFF     = 8'h1C;

	// ==========================================================
	// Field positions
	localparam int SDC_SYS_CLKEN_BIT   = 3;
	localparam int SDC_SYS_FORCE_BIT   = 4;
	localparam int SDC_SYS_RESET_BIT   = 24;
	localparam int SDC_PRS_STABLE_BIT  = 3;
	localparam int SDC_PRS_CARDIN_BIT  = 4;
	localparam int SDC_PRS_ADMA_BIT    = 5;
	localparam int SDC_PRS_GATED_BIT   = 6;
	localparam int SDC_ADMA_START_BIT  = 0;

	// Interrupt status bits
	localparam int SDC_IRQ_W           = 4;
	localparam int SDC_IRQ_DMA_DONE    = 0;
	localparam int SDC_IRQ_XFER_DONE   = 1;
	localparam int SDC_IRQ_CARD_IN     = 2;
	localparam int SDC_IRQ_CARD_OUT    = 3;

	// Descriptor fields: {end, kind[1:0], len[7:0]} in the low bits
	localparam int SDC_DESC_END_BIT    = 10;
	localparam int SDC_DESC_KIND_LO    = 8;
	localparam logic [1:0] SDC_KIND_NOP  = 2'h0;
	localparam logic [1:0] SDC_KIND_MOVE = 2'h2;
	localparam logic [1:0] SDC_KIND_LINK = 2'h3;

	// ==========================================================
	// Reset values and timing
	localparam logic [7:0] SDC_DIV_RESET    = 8'h04;
	localparam int         SDC_CLK_MHZ      = 50;
	localparam int         SDC_SETTLE_NS    = 200;
	localparam int         SDC_SETTLE_CYC   = (SDC_SETTLE_NS * SDC_CLK_MHZ + 999) / 1000;
	localparam int         SDC_GATE_IDLE    = 16;

	typedef enum logic [1:0] {
		SDC_ADMA_IDLE,
		SDC_ADMA_FETCH,
		SDC_ADMA_MOVE
	} sdc_adma_e;

	typedef struct packed {
		logic       last;
		logic [1:0] kind;
		logic [7:0] len;
	} sdc_desc_s;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} sdc_bus_s;

endpackage

// ### design/sdc_card_clock.sv
// Card clock generator: divider, gating and stability tracking
module sdc_card_clock
	import sdc_pkg::*;
(
	// System
	input  wire logic       clk,
	input  wire logic       reset,
	// Control
	input  wire logic       card_clock_enable,
	input  wire logic [7:0] divider,
	// Status
	output logic            card_clock_stable,
	output logic            card_clk,
	output logic            card_tick
);
	logic [7:0] div_cnt_ff;
	logic [7:0] div_seen_ff;
	logic [7:0] settle_ff;
	logic       card_clk_ff;
	logic       tick_ff;

	initial begin
		assert (SDC_SETTLE_CYC >= 1) else $error("settle count too small");
	end

	// ==========================================================
	// Divider; stops low while gated so the pin never glitches
	always_ff @(posedge clk) begin
		if (reset || !card_clock_enable) begin
			div_cnt_ff  <= 8'h00;
			card_clk_ff <= 1'b0;
			tick_ff     <= 1'b0;
		end else if (div_cnt_ff >= divider) begin
			div_cnt_ff  <= 8'h00;
			card_clk_ff <= ~card_clk_ff;
			tick_ff     <= ~card_clk_ff;
		end else begin
			div_cnt_ff <= div_cnt_ff + 8'h01;
			tick_ff    <= 1'b0;
		end
	end

	// ==========================================================
	// Stability: any divider change restarts the settle count
	always_ff @(posedge clk) begin
		if (reset) begin
			div_seen_ff <= SDC_DIV_RESET;
			settle_ff   <= 8'h00;
		end else if (divider != div_seen_ff) begin
			div_seen_ff <= divider;
			settle_ff   <= 8'h00;
		end else if (settle_ff < 8'(SDC_SETTLE_CYC)) begin
			settle_ff <= settle_ff + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			card_clock_stable <= 1'b0;
		end else begin
			card_clock_stable <= (settle_ff >= 8'(SDC_SETTLE_CYC));
		end
	end

	assign card_clk  = card_clk_ff;
	assign card_tick = tick_ff;
endmodule

// ### design/sdc_card_detect.sv
// Card-detect pin synchroniser and insertion/removal event detector
module sdc_card_detect (
	// System
	input  wire logic clk,
	input  wire logic reset,
	// Pin and mux state
	input  wire logic card_detect_pin,
	input  wire logic pin_function_select,
	// Events
	output logic      card_present,
	output logic      card_inserted,
	output logic      card_removed
);
	logic sync1_ff;
	logic sync2_ff;
	logic level_ff;

	// ==========================================================
	// Two-stage synchroniser
	always_ff @(posedge clk) begin
		if (reset) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
		end else begin
			sync1_ff <= card_detect_pin;
			sync2_ff <= sync1_ff;
		end
	end

	// ==========================================================
	// Edges count only while the pin belongs to the controller;
	// discharge forces the tracked level low and so re-arms it
	always_ff @(posedge clk) begin
		if (reset) begin
			level_ff      <= 1'b0;
			card_inserted <= 1'b0;
			card_removed  <= 1'b0;
		end else if (!pin_function_select) begin
			level_ff      <= 1'b0;
			card_inserted <= 1'b0;
			card_removed  <= 1'b0;
		end else begin
			level_ff      <= sync2_ff;
			card_inserted <= sync2_ff && !level_ff;
			card_removed  <= !sync2_ff && level_ff;
		end
	end

	assign card_present = level_ff;
endmodule

// ### design/sdc_host_core.sv
// Card host core: clock control, ADMA2 chain walker, DMA-done status, card detect, registers
// ==========================================================
// What this block does
// - Present state reports card clock stable
// - Clock enable bit gates clock to card
// - No commands or data while clock off
// - Card-detect rising edge flags insertion
// - Detection works again after pin handback
// - Engine accepts move, link, no-op descriptors
// - End bit stops descriptor fetching
// - Force-on bit disables system clock gating
//
// The plain strobed port and the register addresses are this design's own decisions.
module sdc_host_core
	import sdc_pkg::*;
(
	// System
	input  wire logic        clk,
	input  wire logic        reset,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	// Descriptor source
	input  wire logic        desc_valid,
	input  wire logic [10:0] desc_word,
	output logic             desc_fetch,
	// Card bus
	output logic             card_clk,
	output logic             card_cmd_busy,
	output logic             card_data_move,
	// Card detect
	input  wire logic        card_detect_pin,
	input  wire logic        pin_function_select,
	// Clock gate and interrupt
	output logic             sys_clock_gate_en,
	output logic             irq
);
	sdc_bus_s    bus;
	sdc_desc_s   desc;
	sdc_adma_e   adma_ff;
	logic        card_clock_enable_ff;
	logic        system_clock_force_on_ff;
	logic        full_soft_reset_ff;
	logic [7:0]  divider_ff;
	logic [SDC_IRQ_W-1:0] stat_ff;
	logic [SDC_IRQ_W-1:0] irq_en_ff;
	logic [SDC_IRQ_W-1:0] ev;
	logic [SDC_IRQ_W-1:0] clr;
	logic [7:0]  len_ff;
	logic [4:0]  idle_ff;
	logic        gated_ff;
	logic        clk_stable;
	logic        card_tick;
	logic        card_in;
	logic        ins_ev;
	logic        rem_ev;
	logic        soft_rst;
	logic        chain_done;
	logic        xfer_done;
	logic        card_clk_int;
	logic        move_ff;
	logic        desc_lastq;
	logic        cmd_busy_ff;
	logic        gate_ff;
	logic        irq_ff;

	assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
	assign desc = sdc_desc_s'(desc_word);
	assign soft_rst = reset || full_soft_reset_ff;

	function automatic logic hit_wr(input sdc_bus_s b, input logic [7:0] off);
		hit_wr = b.wr && (b.addr == off);
	endfunction

	// ==========================================================
	// Leaf blocks
	sdc_card_clock u_clock (
		.clk               (clk),
		.reset             (reset),
		.card_clock_enable (card_clock_enable_ff),
		.divider           (divider_ff),
		.card_clock_stable (clk_stable),
		.card_clk          (card_clk_int),
		.card_tick         (card_tick)
	);

	sdc_card_detect u_detect (
		.clk                 (clk),
		.reset               (soft_rst),
		.card_detect_pin     (card_detect_pin),
		.pin_function_select (pin_function_select),
		.card_present        (card_in),
		.card_inserted       (ins_ev),
		.card_removed        (rem_ev)
	);

	// ==========================================================
	// System control; reset bit self-clears after one cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			card_clock_enable_ff     <= 1'b0;
			system_clock_force_on_ff <= 1'b0;
			full_soft_reset_ff       <= 1'b0;
		end else if (hit_wr(bus, SDC_SYSCTL_OFF)) begin
			card_clock_enable_ff     <= bus.wdata[SDC_SYS_CLKEN_BIT];
			system_clock_force_on_ff <= bus.wdata[SDC_SYS_FORCE_BIT];
			full_soft_reset_ff       <= bus.wdata[SDC_SYS_RESET_BIT];
		end else begin
			full_soft_reset_ff <= 1'b0;
		end
	end

	// Divider is not protected here: software gates first
	always_ff @(posedge clk) begin
		if (reset) begin
			divider_ff <= SDC_DIV_RESET;
		end else if (hit_wr(bus, SDC_DIVIDER_OFF)) begin
			divider_ff <= bus.wdata[7:0];
		end
	end

	// ==========================================================
	// ADMA2 chain walker
	always_ff @(posedge clk) begin
		if (soft_rst) begin
			adma_ff <= SDC_ADMA_IDLE;
			len_ff  <= 8'h00;
		end else begin
			unique case (adma_ff)
				SDC_ADMA_IDLE: begin
					if (hit_wr(bus, SDC_ADMA_OFF) && bus.wdata[SDC_ADMA_START_BIT]) begin
						adma_ff <= SDC_ADMA_FETCH;
					end
				end
				SDC_ADMA_FETCH: begin
					if (desc_valid) begin
						unique case (desc.kind)
							SDC_KIND_MOVE: begin
								len_ff  <= desc.len;
								adma_ff <= SDC_ADMA_MOVE;
							end
							default: begin
								// Link and no-op move nothing
								if (desc.last) begin
									adma_ff <= SDC_ADMA_IDLE;
								end
							end
						endcase
					end
				end
				SDC_ADMA_MOVE: begin
					// Data moves one unit per card clock tick only
					if (card_clock_enable_ff && card_tick) begin
						if (len_ff == 8'h00) begin
							adma_ff <= desc_lastq ? SDC_ADMA_IDLE : SDC_ADMA_FETCH;
						end else begin
							len_ff <= len_ff - 8'h01;
						end
					end
				end
				default: adma_ff <= SDC_ADMA_IDLE;
			endcase
		end
	end

	// End flag of the move descriptor being worked
	always_ff @(posedge clk) begin
		if (soft_rst) begin
			desc_lastq <= 1'b0;
		end else if (adma_ff == SDC_ADMA_FETCH && desc_valid) begin
			desc_lastq <= desc.last;
		end
	end

	assign chain_done = (adma_ff == SDC_ADMA_MOVE) && card_clock_enable_ff && card_tick
		&& (len_ff == 8'h00) && desc_lastq;
	assign xfer_done  = chain_done || ((adma_ff == SDC_ADMA_FETCH) && desc_valid
		&& desc.last && (desc.kind != SDC_KIND_MOVE));

	always_ff @(posedge clk) begin
		if (soft_rst) begin
			desc_fetch <= 1'b0;
		end else begin
			desc_fetch <= (adma_ff == SDC_ADMA_FETCH) && !desc_valid;
		end
	end

	// ==========================================================
	// Card bus activity, held off while the card clock is gated
	always_ff @(posedge clk) begin
		if (soft_rst) begin
			move_ff     <= 1'b0;
			cmd_busy_ff <= 1'b0;
		end else begin
			move_ff     <= card_clock_enable_ff && (adma_ff == SDC_ADMA_MOVE);
			cmd_busy_ff <= card_clock_enable_ff && (adma_ff != SDC_ADMA_IDLE);
		end
	end

	// ==========================================================
	// System clock auto-gate: idle long enough and not forced on
	always_ff @(posedge clk) begin
		if (reset) begin
			idle_ff <= 5'h00;
			gated_ff <= 1'b0;
		end else if (system_clock_force_on_ff || bus.wr || bus.rd
				|| adma_ff != SDC_ADMA_IDLE) begin
			idle_ff  <= 5'h00;
			gated_ff <= 1'b0;
		end else if (idle_ff < 5'(SDC_GATE_IDLE)) begin
			idle_ff <= idle_ff + 5'h01;
		end else begin
			gated_ff <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			gate_ff <= 1'b0;
		end else begin
			gate_ff <= gated_ff;
		end
	end

	// ==========================================================
	// Interrupt status: sticky, set beats clear
	assign ev = {rem_ev, ins_ev, xfer_done, chain_done};
	assign clr = hit_wr(bus, SDC_IRQ_CLR_OFF) ? bus.wdata[SDC_IRQ_W-1:0] : '0;

	// Clear path ignores gating, so the done flag can always be cleared
	always_ff @(posedge clk) begin
		if (soft_rst) begin
			stat_ff <= '0;
		end else begin
			stat_ff <= (stat_ff & ~clr) | ev;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			irq_en_ff <= '0;
		end else if (hit_wr(bus, SDC_IRQ_EN_OFF)) begin
			irq_en_ff <= bus.wdata[SDC_IRQ_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(((stat_ff & ~clr) | ev) & irq_en_ff);
		end
	end

	// ==========================================================
	// Read data, one cycle after the strobe
	always_ff @(posedge clk) begin
		if (reset || !bus.rd) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			reg_rdata <= 32'h0000_0000;
			case (bus.addr)
				SDC_SYSCTL_OFF: begin
					reg_rdata[SDC_SYS_CLKEN_BIT] <= card_clock_enable_ff;
					reg_rdata[SDC_SYS_FORCE_BIT] <= system_clock_force_on_ff;
				end
				SDC_PRESENT_OFF: begin
					reg_rdata[SDC_PRS_STABLE_BIT] <= clk_stable;
					reg_rdata[SDC_PRS_CARDIN_BIT] <= card_in;
					reg_rdata[SDC_PRS_ADMA_BIT]   <= (adma_ff != SDC_ADMA_IDLE);
					reg_rdata[SDC_PRS_GATED_BIT]  <= gated_ff;
				end
				SDC_DIVIDER_OFF: reg_rdata[7:0] <= divider_ff;
				SDC_IRQ_STAT_OFF: reg_rdata[SDC_IRQ_W-1:0] <= stat_ff;
				SDC_IRQ_EN_OFF: reg_rdata[SDC_IRQ_W-1:0] <= irq_en_ff;
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end
	end

	assign card_clk          = card_clk_int;
	assign card_cmd_busy     = cmd_busy_ff;
	assign card_data_move    = move_ff;
	assign sys_clock_gate_en = gate_ff;
	assign irq               = irq_ff;
endmodule

// ### sim/sdc_host_core_monitor.sv
// Checker for the card host core ports
module sdc_host_core_monitor
	import sdc_pkg::*;
(
	// System
	input wire logic        clk,
	input wire logic        reset,
	// Register port
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	// Descriptors
	input wire logic        desc_valid,
	input wire logic [10:0] desc_word,
	input wire logic        desc_fetch,
	// Card side and status
	input wire logic        card_clk,
	input wire logic        card_cmd_busy,
	input wire logic        card_data_move,
	input wire logic        sys_clock_gate_en,
	input wire logic        irq
);
	// ====
	// Shadow of the control bits
	logic en_ff;
	logic en_d_ff;
	logic fo_ff;
	logic fo_d_ff;
	wire  take    = desc_fetch && desc_valid;
	wire  is_move = desc_word[9:8] == SDC_KIND_MOVE;
	wire  clk_off = !en_ff && !en_d_ff;
	always_ff @(posedge clk) begin
		if (reset) begin
			en_ff <= 1'b0;
			fo_ff <= 1'b0;
		end else if (reg_wr && reg_addr == SDC_SYSCTL_OFF) begin
			en_ff <= reg_wdata[SDC_SYS_CLKEN_BIT];
			fo_ff <= reg_wdata[SDC_SYS_FORCE_BIT];
		end
	end
	// Delayed copy hides the registered lag of the outputs
	always_ff @(posedge clk) begin
		en_d_ff <= en_ff;
		fo_d_ff <= fo_ff;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// ====
	// Assertions
	chk_clk_gated: assert property (clk_off |-> !card_clk)
		else $error("card clock runs while gated");
	chk_bus_quiet: assert property (clk_off |-> !card_cmd_busy && !card_data_move)
		else $error("card bus active while clock off");
	chk_force_hold: assert property (fo_ff && fo_d_ff |-> !sys_clock_gate_en)
		else $error("gating while forced on");
	chk_gate_busy: assert property (card_data_move |-> !sys_clock_gate_en)
		else $error("gating during data move");
	chk_last_stops: assert property (take && desc_word[10] |=> ##1 !desc_fetch [*3])
		else $error("fetch after end descriptor");
	chk_move_runs: assert property (take && is_move && !clk_off |-> ##[1:3] card_data_move)
		else $error("move descriptor moved nothing");
	chk_skip_fetch: assert property (take && !is_move && !desc_word[10]
		|=> !card_data_move ##[0:3] desc_fetch)
		else $error("skip descriptor mishandled");
	chk_irq_clear: assert property (reg_wr && reg_addr == SDC_IRQ_CLR_OFF
		&& reg_wdata[3:0] == 4'hF |-> ##2 !irq)
		else $error("irq stays after clear");
	cover property (take && is_move);
	cover property ($rose(irq));
	cover property ($rose(sys_clock_gate_en));
endmodule

// ### sim/sdc_card_model.sv
// Card model: detect pull-up and discharge of the detect pin
module sdc_card_model (
	// Bench control
	input  wire logic inserted,
	input  wire logic pin_function_select,
	// Detect pin
	output logic      card_detect_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// Weak pulldown cannot lower the pin, so a pulled card leaves it high
	initial card_detect_pin = 1'b0;
	always @(inserted or pin_function_select) begin
		if (!pin_function_select)
			card_detect_pin = 1'b0;
		else if (inserted)
			card_detect_pin = 1'b1;
	end
endmodule

// ### sim/test_sdc_host_core.sv
// Self-checking bench for the card host core
module test_sdc_host_core
	import sdc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ====
	// Wiring
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        desc_valid = 1'b0;
	logic [10:0] desc_word = 11'h0;
	logic        pin_function_select = 1'b1;
	logic        inserted = 1'b0;
	logic        pend = 1'b0;
	logic        ck_prev = 1'b0;
	logic [63:0] note_q[$];
	logic [63:0] note;
	logic [1:0]  kinds[2] = '{SDC_KIND_NOP, SDC_KIND_LINK};
	logic [31:0] reg_rdata;
	logic        desc_fetch, card_clk, card_cmd_busy, card_data_move;
	logic        card_detect_pin, sys_clock_gate_en, irq;
	int          num_errors = 0;
	int          compares = 0;
	int          rises = 0;
	int          cycles = 0;
	int          r0, div, len;
	initial forever #10 clk = ~clk;
	sdc_host_core dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.desc_valid(desc_valid), .desc_word(desc_word), .desc_fetch(desc_fetch),
		.card_clk(card_clk), .card_cmd_busy(card_cmd_busy), .card_data_move(card_data_move),
		.card_detect_pin(card_detect_pin), .pin_function_select(pin_function_select),
		.sys_clock_gate_en(sys_clock_gate_en), .irq(irq));
	sdc_card_model card (.inserted(inserted), .pin_function_select(pin_function_select),
		.card_detect_pin(card_detect_pin));
	// ====
	// Tasks
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// Mask drops bits whose value is not under test
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		@(posedge clk);
		note_q.push_back({m, e & m});
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask
	// Present a word only once the engine asks, so none is taken twice
	task automatic desc(input logic [10:0] w);
		int i;
		i = 0;
		do begin
			@(posedge clk);
			#1;
			i++;
		end while (desc_fetch !== 1'b1 && i < 60);
		desc_valid <= 1'b1;
		desc_word <= w;
		@(posedge clk);
		#1;
		desc_valid <= 1'b0;
		desc_word <= ~w;
	endtask
	task automatic wait_irq(input logic lvl);
		for (int i = 0; i < 400 && irq !== lvl; i++) begin
			@(posedge clk);
			#1;
		end
		chk("irq", irq, lvl);
	endtask
	// ====
	// Result watcher and timeout
	always @(posedge clk) begin
		pend <= reg_rd;
		ck_prev <= card_clk;
		if (card_clk && !ck_prev)
			rises++;
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			report_and_stop();
		end
	end
	always @(negedge clk) begin
		if (pend) begin
			note = note_q.pop_front();
			chk("reg_rdata", reg_rdata & note[63:32], note[31:0]);
		end
	end
	// ====
	// Scenarios
	initial begin
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		void'($urandom(32'h1F99));
		rd(SDC_SYSCTL_OFF, 32'h0, '1);
		rd(SDC_DIVIDER_OFF, {24'h0, SDC_DIV_RESET}, '1);
		rd(SDC_IRQ_CLR_OFF, 32'h0, '1);
		rd(8'h20, 32'h0, '1);
		$display("reset test done");
		div = $urandom_range(3, 1);
		wr(SDC_SYSCTL_OFF, 32'h0);
		wr(SDC_DIVIDER_OFF, div);
		repeat (SDC_SETTLE_CYC + 4) @(posedge clk);
		rd(SDC_PRESENT_OFF, 32'h8, 32'h8);
		wr(SDC_SYSCTL_OFF, 32'h18);
		repeat (2 * (div + 1)) @(posedge clk);
		#1;
		r0 = rises;
		repeat (8 * (div + 1)) @(posedge clk);
		#1;
		chk("card_clk rises", rises - r0, 4);
		$display("clock test done");
		len = $urandom_range(3, 0);
		wr(SDC_IRQ_EN_OFF, 32'hF);
		wr(SDC_ADMA_OFF, 32'h1);
		desc({1'b0, SDC_KIND_NOP, 8'h00});
		desc({1'b0, SDC_KIND_LINK, 8'h00});
		desc({1'b1, SDC_KIND_MOVE, len[7:0]});
		wait_irq(1'b1);
		rd(SDC_IRQ_STAT_OFF, 32'h3, 32'hF);
		rd(SDC_PRESENT_OFF, 32'h0, 32'h20);
		wr(SDC_SYSCTL_OFF, 32'h8);
		repeat (SDC_GATE_IDLE + 4) @(posedge clk);
		#1;
		chk("gate", sys_clock_gate_en, 1'b1);
		wr(SDC_IRQ_CLR_OFF, 32'hF);
		rd(SDC_IRQ_STAT_OFF, 32'h0, 32'hF);
		wait_irq(1'b0);
		foreach (kinds[k]) begin
			wr(SDC_ADMA_OFF, 32'h1);
			desc({1'b1, kinds[k], 8'h00});
			wait_irq(1'b1);
			rd(SDC_IRQ_STAT_OFF, 32'h2, 32'hF);
			wr(SDC_IRQ_CLR_OFF, 32'hF);
		end
		wr(SDC_SYSCTL_OFF, 32'h0);
		wr(SDC_ADMA_OFF, 32'h1);
		desc({1'b1, SDC_KIND_MOVE, 8'h00});
		repeat (40) @(posedge clk);
		#1;
		chk("stalled irq", irq, 1'b0);
		wr(SDC_SYSCTL_OFF, 32'h8);
		wait_irq(1'b1);
		// Soft reset empties status but keeps the control bits
		wr(SDC_SYSCTL_OFF, 32'h0100_0008);
		rd(SDC_IRQ_STAT_OFF, 32'h0, 32'hF);
		rd(SDC_SYSCTL_OFF, 32'h8, '1);
		wr(SDC_IRQ_CLR_OFF, 32'hF);
		$display("dma test done");
		inserted <= 1'b1;
		repeat (10) @(posedge clk);
		rd(SDC_IRQ_STAT_OFF, 32'h4, 32'h4);
		rd(SDC_PRESENT_OFF, 32'h10, 32'h10);
		for (int n = 0; n < 3; n++) begin
			if (n == 2)
				inserted <= 1'b0;
			wr(SDC_IRQ_CLR_OFF, 32'hF);
			pin_function_select <= 1'b0;
			repeat (10) @(posedge clk);
			pin_function_select <= 1'b1;
			repeat (10) @(posedge clk);
			rd(SDC_IRQ_STAT_OFF, n < 2 ? 32'h4 : 32'h0, 32'h4);
		end
		rd(SDC_PRESENT_OFF, 32'h0, 32'h10);
		$display("detect test done");
		report_and_stop();
	end
endmodule

bind sdc_host_core sdc_host_core_monitor u_mon (.clk(clk), .reset(reset),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .desc_valid(desc_valid),
	.desc_word(desc_word), .desc_fetch(desc_fetch), .card_clk(card_clk),
	.card_cmd_busy(card_cmd_busy), .card_data_move(card_data_move),
	.sys_clock_gate_en(sys_clock_gate_en), .irq(irq));
